// file: rtl/bst_regs.svh
// Constants of the boundary scan test port.
`ifndef BST_REGS_SVH
`define BST_REGS_SVH

// ****************************************************************
// Instruction register
// ****************************************************************
`define BST_IR_W          3
`define BST_IR_BOUNDARY   3'h0
`define BST_IR_CACHE_TEST 3'h3
`define BST_IR_RESET      3'h7
`define BST_IR_CAPTURE    3'h1

// ****************************************************************
// Boundary chain layout, index 0 nearest the serial input
// ****************************************************************
`define BST_CHAIN_LEN     58
`define BST_CELL_BUS_BIT4 0
`define BST_CELL_TEST_PIN 35
`define BST_CELL_PLL_PIN  36
`define BST_CELL_BUS_OE   57

// ****************************************************************
// Timing
// ****************************************************************
`define BST_SYNC_STAGES   2

`endif

// file: rtl/bst_pkg.sv
// Types of the boundary scan test port.
package bst_pkg;

  // ****************************************************************
  // Port controller states
  // ****************************************************************
  typedef enum logic [3:0] {
    BST_TLR, BST_RTI,
    BST_SEL_DR, BST_CAP_DR, BST_SHF_DR, BST_EX1_DR,
    BST_PAU_DR, BST_EX2_DR, BST_UPD_DR,
    BST_SEL_IR, BST_CAP_IR, BST_SHF_IR, BST_EX1_IR,
    BST_PAU_IR, BST_EX2_IR, BST_UPD_IR
  } bst_state_t;

  // ****************************************************************
  // Serial link pins from the tester
  // ****************************************************************
  typedef struct packed {
    logic test_serial_clock;
    logic test_mode_select;
    logic serial_test_in;
  } bst_link_t;

endpackage : bst_pkg

// file: rtl/bst_test_port.sv
// Boundary scan test port: controller, instruction, bypass and chain.
`timescale 1ns/1ps
`include "bst_regs.svh"

module bst_test_port #(
  parameter int CHAIN_LEN = `BST_CHAIN_LEN
) (
  // Clock and reset
  input  wire logic                   clock_in,
  input  wire logic                   nrst_in,
  // Serial link from the tester
  input  wire bst_pkg::bst_link_t     link_in,
  output logic                        serial_test_out,
  output logic                        serial_test_oe_out,
  // Pin values seen by the chain and values it forces
  input  wire logic [CHAIN_LEN-1:0]   pins_in,
  output logic      [CHAIN_LEN-1:0]   pins_force_out,
  output logic                        pins_force_en_out,
  output logic                        pll_bypass_pin_out,
  output logic                        factory_test_pin_out,
  // Test features
  output logic                        cache_test_latch_out
);
  import bst_pkg::*;

  // The cell order is fixed, so any other length cannot be served.
  if (CHAIN_LEN != `BST_CHAIN_LEN) begin : g_bad_chain_len
    $error("Chain length must match the fixed cell order.");
  end

  // ****************************************************************
  // Synchronisers
  // ****************************************************************
  // Link pins and pin values are from outside the clock domain.
  bst_link_t                 link_meta_reg;
  bst_link_t                 link_sync_reg;
  logic                      tck_prev_reg;
  logic [CHAIN_LEN-1:0]      pins_meta_reg;
  logic [CHAIN_LEN-1:0]      pins_sync_reg;
  logic                      tck_rise;
  logic                      tck_fall;

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      link_meta_reg <= '0;
      link_sync_reg <= '0;
      tck_prev_reg  <= 1'b0;
    end else begin
      link_meta_reg <= link_in;
      link_sync_reg <= link_meta_reg;
      tck_prev_reg  <= link_sync_reg.test_serial_clock;
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pins_meta_reg <= '0;
      pins_sync_reg <= '0;
    end else begin
      pins_meta_reg <= pins_in;
      pins_sync_reg <= pins_meta_reg;
    end
  end

  // Edges are seen two to three clocks late, so the test clock must
  // stay well below a quarter of this clock.
  assign tck_rise = link_sync_reg.test_serial_clock & ~tck_prev_reg;
  assign tck_fall = ~link_sync_reg.test_serial_clock & tck_prev_reg;

  // ****************************************************************
  // Port controller
  // ****************************************************************
  bst_state_t state_reg;
  bst_state_t state_next;
  logic       tms;

  assign tms = link_sync_reg.test_mode_select;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      BST_TLR:    state_next = tms ? BST_TLR    : BST_RTI;
      BST_RTI:    state_next = tms ? BST_SEL_DR : BST_RTI;
      BST_SEL_DR: state_next = tms ? BST_SEL_IR : BST_CAP_DR;
      BST_CAP_DR: state_next = tms ? BST_EX1_DR : BST_SHF_DR;
      BST_SHF_DR: state_next = tms ? BST_EX1_DR : BST_SHF_DR;
      BST_EX1_DR: state_next = tms ? BST_UPD_DR : BST_PAU_DR;
      BST_PAU_DR: state_next = tms ? BST_EX2_DR : BST_PAU_DR;
      BST_EX2_DR: state_next = tms ? BST_UPD_DR : BST_SHF_DR;
      BST_UPD_DR: state_next = tms ? BST_SEL_DR : BST_RTI;
      BST_SEL_IR: state_next = tms ? BST_TLR    : BST_CAP_IR;
      BST_CAP_IR: state_next = tms ? BST_EX1_IR : BST_SHF_IR;
      BST_SHF_IR: state_next = tms ? BST_EX1_IR : BST_SHF_IR;
      BST_EX1_IR: state_next = tms ? BST_UPD_IR : BST_PAU_IR;
      BST_PAU_IR: state_next = tms ? BST_EX2_IR : BST_PAU_IR;
      BST_EX2_IR: state_next = tms ? BST_UPD_IR : BST_SHF_IR;
      BST_UPD_IR: state_next = tms ? BST_SEL_DR : BST_RTI;
    endcase
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_reg <= BST_TLR;
    end else if (tck_rise) begin
      state_reg <= state_next;
    end
  end

  // ****************************************************************
  // Instruction register
  // ****************************************************************
  logic [`BST_IR_W-1:0] ir_shift_reg;
  logic [`BST_IR_W-1:0] ir_reg;
  logic                 sel_boundary;

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ir_shift_reg <= `BST_IR_RESET;
    end else if (tck_rise) begin
      if (state_reg == BST_CAP_IR) begin
        ir_shift_reg <= `BST_IR_CAPTURE;
      end else if (state_reg == BST_SHF_IR) begin
        ir_shift_reg <= {link_sync_reg.serial_test_in,
                         ir_shift_reg[`BST_IR_W-1:1]};
      end
    end
  end

  // The instruction changes on the falling test clock edge.
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ir_reg <= `BST_IR_RESET;
    end else if (tck_fall) begin
      if (state_reg == BST_TLR) begin
        ir_reg <= `BST_IR_RESET;
      end else if (state_reg == BST_UPD_IR) begin
        ir_reg <= ir_shift_reg;
      end
    end
  end

  // Only the all-zero code reaches the chain; 011 and every other
  // code with a one keep the bypass flip-flop in the path.
  assign sel_boundary = (ir_reg == `BST_IR_BOUNDARY);

  // ****************************************************************
  // Cache test latch
  // ****************************************************************
  // Only processor reset clears it; leaving the test state does not.
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cache_test_latch_out <= 1'b0;
    end else if (tck_fall && state_reg == BST_UPD_IR &&
                 ir_shift_reg == `BST_IR_CACHE_TEST) begin
      cache_test_latch_out <= 1'b1;
    end
  end

  // ****************************************************************
  // Data registers
  // ****************************************************************
  logic                 bypass_reg;
  logic [CHAIN_LEN-1:0] chain_shift_reg;
  logic [CHAIN_LEN-1:0] chain_hold_reg;
  logic [CHAIN_LEN-1:0] chain_reset_val;

  always_comb begin
    chain_reset_val = '0;
    chain_reset_val[`BST_CELL_TEST_PIN] = 1'b1;
    chain_reset_val[`BST_CELL_PLL_PIN]  = 1'b1;
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      bypass_reg <= 1'b0;
    end else if (tck_rise && !sel_boundary) begin
      if (state_reg == BST_CAP_DR) begin
        bypass_reg <= 1'b0;
      end else if (state_reg == BST_SHF_DR) begin
        bypass_reg <= link_sync_reg.serial_test_in;
      end
    end
  end

  // Cell 0 sits next to the serial input, the last next to the output.
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      chain_shift_reg <= '0;
    end else if (tck_rise && sel_boundary) begin
      if (state_reg == BST_CAP_DR) begin
        chain_shift_reg <= pins_sync_reg;
      end else if (state_reg == BST_SHF_DR) begin
        chain_shift_reg <= {chain_shift_reg[CHAIN_LEN-2:0],
                            link_sync_reg.serial_test_in};
      end
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      chain_hold_reg <= '0;
    end else if (tck_fall && sel_boundary && state_reg == BST_UPD_DR) begin
      chain_hold_reg <= chain_shift_reg;
    end
  end

  // ****************************************************************
  // Pin forcing
  // ****************************************************************
  // The two strap cells read deasserted until a boundary update.
  logic force_valid_reg;

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      force_valid_reg <= 1'b0;
    end else if (tck_fall && sel_boundary && state_reg == BST_UPD_DR) begin
      force_valid_reg <= 1'b1;
    end else if (tck_fall && state_reg == BST_TLR) begin
      force_valid_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pins_force_out       <= '0;
      pins_force_en_out    <= 1'b0;
      pll_bypass_pin_out   <= 1'b1;
      factory_test_pin_out <= 1'b1;
    end else begin
      pins_force_out       <= force_valid_reg ? chain_hold_reg
                                              : chain_reset_val;
      pins_force_en_out    <= sel_boundary & force_valid_reg;
      pll_bypass_pin_out   <= force_valid_reg ?
                              chain_hold_reg[`BST_CELL_PLL_PIN] :
                              1'b1;
      factory_test_pin_out <= force_valid_reg ?
                              chain_hold_reg[`BST_CELL_TEST_PIN] :
                              1'b1;
    end
  end

  // ****************************************************************
  // Serial output
  // ****************************************************************
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      serial_test_out    <= 1'b0;
      serial_test_oe_out <= 1'b0;
    end else if (tck_fall) begin
      serial_test_oe_out <= (state_reg == BST_SHF_DR) ||
                            (state_reg == BST_SHF_IR);
      if (state_reg == BST_SHF_IR) begin
        serial_test_out <= ir_shift_reg[0];
      end else if (sel_boundary) begin
        serial_test_out <= chain_shift_reg[`BST_CELL_BUS_OE];
      end else begin
        serial_test_out <= bypass_reg;
      end
    end
  end

endmodule : bst_test_port

// file: dv/bst_test_port_assertions.sv
// Port checks of the boundary scan test port, bound into the design.
`timescale 1ns/1ps
`include "bst_regs.svh"
module bst_test_port_assertions #(
  parameter int CHAIN_LEN = 58
) (
  // Clock and reset
  input wire logic                 clock_in,
  input wire logic                 nrst_in,
  // Serial link and pins
  input wire bst_pkg::bst_link_t   link_in,
  input wire logic                 serial_test_out,
  input wire logic                 serial_test_oe_out,
  input wire logic [CHAIN_LEN-1:0] pins_in,
  input wire logic [CHAIN_LEN-1:0] pins_force_out,
  input wire logic                 pins_force_en_out,
  input wire logic                 pll_bypass_pin_out,
  input wire logic                 factory_test_pin_out,
  input wire logic                 cache_test_latch_out
);
  import bst_pkg::*;
  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!nrst_in);
  latch_sticky_a: assert property ($past(cache_test_latch_out) |->
    cache_test_latch_out) else $error("cache latch dropped");
  latch_set_a: assert property ($rose(cache_test_latch_out) |->
    !serial_test_oe_out ##1 cache_test_latch_out[*3])
    else $error("cache latch set during a shift");
  force_hold_a: assert property ($changed(pins_force_out) |->
    !serial_test_oe_out) else $error("forced pins moved in a shift");
  strap_follow_a: assert property (pins_force_en_out |->
    pll_bypass_pin_out == pins_force_out[`BST_CELL_PLL_PIN] &&
    factory_test_pin_out == pins_force_out[`BST_CELL_TEST_PIN])
    else $error("strap outputs differ from chain");
  tdo_timing_a: assert property ($changed(serial_test_out) |->
    !$past(link_in.test_serial_clock, 2)) else $error("tdo off fall");
  oe_timing_a: assert property ($changed(serial_test_oe_out) |->
    !$past(link_in.test_serial_clock, 2)) else $error("oe off fall");
  en_rise_a: assert property ($rose(pins_force_en_out) |->
    !serial_test_oe_out) else $error("forcing began in a shift");
  en_fall_a: assert property ($fell(pins_force_en_out) |->
    !serial_test_oe_out) else $error("forcing ended in a shift");
  cover property ($rose(cache_test_latch_out));
  cover property ($rose(pins_force_en_out));
  cover property ($fell(pins_force_en_out));
endmodule : bst_test_port_assertions

bind bst_test_port bst_test_port_assertions #(.CHAIN_LEN(CHAIN_LEN)) chk (
  .clock_in, .nrst_in, .link_in, .serial_test_out, .serial_test_oe_out,
  .pins_in, .pins_force_out, .pins_force_en_out, .pll_bypass_pin_out,
  .factory_test_pin_out, .cache_test_latch_out);

// file: dv/bst_tester_model.sv
// Board tester model that drives the serial test link one bit a step.
`timescale 1ns/1ps
module bst_tester_model (
  // Clock that paces the link
  input  wire logic         clock_in,
  // Link towards the test port
  output bst_pkg::bst_link_t link_out,
  input  wire logic         tdo_in,
  input  wire logic         oe_in
);
  import bst_pkg::*;
  event got;
  logic got_val;
  initial link_out = '0;
  // ************************************************************
  // One test clock period of 160 ns
  // ************************************************************
  // Data moves at the fall so it is long settled at the rise; the
  // clock stays low between steps.
  task automatic step(input logic tms, input logic tdi);
    link_out.test_mode_select = tms;
    link_out.serial_test_in = tdi;
    repeat (4) @(posedge clock_in);
    #1;
    if (oe_in === 1'b1) begin
      got_val = tdo_in;
      -> got;
    end
    link_out.test_serial_clock = 1'b1;
    repeat (4) @(posedge clock_in);
    #1 link_out.test_serial_clock = 1'b0;
  endtask : step
endmodule : bst_tester_model

// file: dv/bst_test_port_test.sv
// Self-checking bench of the boundary scan test port.
`timescale 1ns/1ps
`include "bst_regs.svh"
module bst_test_port_test;
  import bst_pkg::*;
  logic clock_in = 0;
  logic nrst_in = 0;
  bst_link_t link_in;
  logic serial_test_out, serial_test_oe_out, pins_force_en_out;
  logic pll_bypass_pin_out, factory_test_pin_out, cache_test_latch_out;
  logic [57:0] pins_in, pins_force_out, pat;
  logic [63:0] din, dexp;
  logic q[$];
  integer seed = 98;
  integer err_count = 0;
  integer check_count = 0;
  int c, k;
  always #10 clock_in = ~clock_in;
  bst_test_port uut (.clock_in, .nrst_in, .link_in, .serial_test_out,
    .serial_test_oe_out, .pins_in, .pins_force_out, .pins_force_en_out,
    .pll_bypass_pin_out, .factory_test_pin_out, .cache_test_latch_out);
  bst_tester_model tp (.clock_in, .link_out(link_in),
    .tdo_in(serial_test_out), .oe_in(serial_test_oe_out));
  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic scan(input bit ir, input int n,
                      input logic [63:0] d, input logic [63:0] e);
    int i;
    for (i = 0; i < n; i++) q.push_back(e[i]);
    tp.step(1'b1, 1'b0);
    if (ir) tp.step(1'b1, 1'b0);
    tp.step(1'b0, 1'b0);
    tp.step(1'b0, 1'b0);
    for (i = 0; i < n; i++) tp.step(i == n - 1, d[i]);
    tp.step(1'b1, 1'b0);
    tp.step(1'b0, 1'b0);
  endtask : scan
  task automatic to_reset_state;
    repeat (5) tp.step(1'b1, 1'b0);
    tp.step(1'b0, 1'b0);
  endtask : to_reset_state
  task complete_run;
    $display("Counts: %0d checks, %0d mismatches", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run
  // Results appear only while the port drives its serial output.
  always @(tp.got) begin
    if (q.size() == 0) check(64'h1, 64'h0);
    else check(64'(tp.got_val), 64'(q.pop_front()));
  end
  initial begin
    #200000;
    err_count++;
    complete_run();
  end
  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    din = {$random(seed), $random(seed)};
    pins_in = din[57:0];
    din = {$random(seed), $random(seed)};
    pat = din[57:0];
    repeat (4) @(posedge clock_in);
    #1 nrst_in = 1'b1;
    check(64'({pins_force_en_out, cache_test_latch_out, serial_test_oe_out,
      pll_bypass_pin_out, factory_test_pin_out}), 64'h3);
    check(64'(pins_force_out), 64'h0);
    $display("test reset done");
    to_reset_state();
    scan(1'b1, 3, 64'h0, 64'h1);
    for (k = 0; k < 58; k++) begin
      din[k] = pat[57-k];
      dexp[k] = pins_in[57-k];
    end
    scan(1'b0, 58, din, dexp);
    check(64'(pins_force_out), 64'(pat));
    check(64'(pins_force_en_out), 64'h1);
    check(64'({pll_bypass_pin_out, factory_test_pin_out}),
      64'({pat[`BST_CELL_PLL_PIN], pat[`BST_CELL_TEST_PIN]}));
    $display("test boundary chain done");
    for (c = 1; c < 8; c++) begin
      scan(1'b1, 3, 64'(c), 64'h1);
      scan(1'b0, 2, 64'h1, 64'h2);
      check(64'(cache_test_latch_out), 64'(c >= 3));
      check(64'(pins_force_en_out), 64'h0);
    end
    $display("test instruction codes done");
    to_reset_state();
    check(64'(cache_test_latch_out), 64'h1);
    scan(1'b0, 2, 64'h1, 64'h2);
    check(64'(q.size()), 64'h0);
    $display("test logic reset done");
    // Only processor reset may clear the sticky latch.
    @(posedge clock_in);
    #1 nrst_in = 1'b0;
    repeat (2) @(posedge clock_in);
    #1 nrst_in = 1'b1;
    check(64'(cache_test_latch_out), 64'h0);
    to_reset_state();
    scan(1'b0, 2, 64'h1, 64'h2);
    check(64'(q.size()), 64'h0);
    $display("test processor reset done");
    complete_run();
  end
endmodule : bst_test_port_test
